// file: verilog/flash_host_pkg.sv
// constants for the host-side controller of a two-bank parallel flash
// assumes a 20 MHz clock and an apb master on the software side
package flash_host_pkg;

   localparam int CLK_NS = 50;

   // pin timing, in nanoseconds
   localparam int T_WE_NS = 60;
   localparam int T_ACC_NS = 120;
   localparam int T_PD_PULSE_NS = 100;
   localparam int T_RESET_TO_OUTPUT_NS = 600;
   localparam int T_RESET_TO_WRITE_NS = 1000;
   localparam int T_POLL_SETTLE_NS = 500;

   // least times round up, never below one cycle
   function automatic logic [7:0] cycMin(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      if (c < 1) begin
         c = 1;
      end
      return c[7:0];
   endfunction

   localparam logic [7:0] WE_CYC = cycMin(T_WE_NS);
   localparam logic [7:0] PD_PULSE_CYC = cycMin(T_PD_PULSE_NS);
   localparam logic [7:0] SYNC_CYC = 8'h04;
   localparam logic [7:0] RD_CYC = cycMin(T_ACC_NS) + SYNC_CYC;
   localparam logic [7:0] RESET_TO_OUTPUT_CYC = cycMin(T_RESET_TO_OUTPUT_NS);
   localparam logic [7:0] RESET_TO_WRITE_CYC = cycMin(T_RESET_TO_WRITE_NS);
   localparam logic [7:0] POLL_CYC = cycMin(T_POLL_SETTLE_NS);

   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] ADDR_OFS = 8'h04;
   localparam logic [7:0] WDATA_OFS = 8'h08;
   localparam logic [7:0] RDATA_OFS = 8'h0c;
   localparam logic [7:0] STATUS_OFS = 8'h10;

   // control fields
   localparam int CTRL_GO = 0;
   localparam int CTRL_OP_LO = 1;
   localparam int CTRL_BANK = 3;
   localparam int CTRL_WIDE = 4;
   localparam int CTRL_LOCK_OVR = 5;

   // status fields
   localparam int STAT_BUSY = 0;
   localparam int STAT_READY = 1;
   localparam int STAT_PULSE = 2;
   localparam int STAT_WAKE = 3;

   localparam logic [1:0] OP_WRITE = 2'h0;
   localparam logic [1:0] OP_READ = 2'h1;
   localparam logic [1:0] OP_POLL = 2'h2;
   localparam logic [1:0] OP_RESET = 2'h3;

   localparam logic [15:0] DQ_RESET = 16'h0000;

   typedef enum {
      IDLE, PDOWN, WSETUP, WPULSE, WHOLD, RACCESS, RSAMPLE, POLL
   } state_e;

endpackage

// file: verilog/pin_sync.sv
// three-flop synchroniser for pins from the flash
// a change is taken once the second and third flops agree
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // pin side
   input wire logic [WIDTH-1:0] d,
   // clocked side
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] s1_ff;
   logic [WIDTH-1:0] s2_ff;
   logic [WIDTH-1:0] s3_ff;
   logic [WIDTH-1:0] q_ff;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         s1_ff <= INIT;
         s2_ff <= INIT;
         s3_ff <= INIT;
      end else begin
         s1_ff <= d;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // glitch of one cycle never reaches q
   always_ff @(posedge clk) begin
      if (!resetn) begin
         q_ff <= INIT;
      end else if (s2_ff == s3_ff) begin
         q_ff <= s3_ff;
      end
   end

   assign q = q_ff;

endmodule

// file: verilog/flash_host_ctrl.sv
// host controller driving a two-bank parallel flash through its pins
// software reaches it over apb; the flash is outside, on asynchronous pins
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module flash_host_ctrl (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // flash address and data
   output logic [20:0] flashAddr,
   output logic [15:0] dqOut,
   output logic dqOeN,
   input wire logic [15:0] dqIn,
   // flash control
   output logic bank0_select_n,
   output logic bank1_low_select_n,
   output logic bank1_high_select_n,
   output logic weN,
   output logic oeN,
   output logic powerdown_reset_n,
   output logic byteN,
   output logic lockOverrideN,
   // open-drain status pin, read as high when released
   input wire logic status_output_pin
);

   ////////////////////////////////////////////////////////////////////////
   flash_host_pkg::state_e state_ff;
   flash_host_pkg::state_e nxt_state;
   logic [7:0] cnt_ff;
   logic [7:0] nxt_cnt;
   logic [7:0] wakeCnt_ff;
   logic [1:0] op_ff;
   logic bank_ff;
   logic wide_ff;
   logic lockOvr_ff;
   logic [20:0] addr_ff;
   logic [15:0] wdata_ff;
   logic [15:0] rdata_ff;
   logic [31:0] prdata_ff;
   logic pulseSeen_ff;
   logic statusPrev_ff;
   logic weN_ff;
   logic oeN_ff;
   logic dqOeN_ff;
   logic pdownN_ff;
   logic bankActive_ff;
   logic [15:0] dqSync;
   logic statusSync;
   logic readOk;
   logic writeOk;
   logic busy;
   logic apbWrite;
   logic apbSetup;
   logic mapped;
   logic go;
   logic statusFall;

   ////////////////////////////////////////////////////////////////////////
   pin_sync #(.WIDTH(16), .INIT(flash_host_pkg::DQ_RESET)) dqSyncInst (
      .clk(clk),
      .resetn(resetn),
      .d(dqIn),
      .q(dqSync)
   );

   pin_sync #(.WIDTH(1), .INIT(1'b1)) statusSyncInst (
      .clk(clk),
      .resetn(resetn),
      .d(status_output_pin),
      .q(statusSync)
   );

   ////////////////////////////////////////////////////////////////////////
   // apb: zero wait states, read data loaded in the setup cycle
   assign apbSetup = psel && !penable;
   assign apbWrite = psel && penable && pwrite;
   assign mapped = (paddr == flash_host_pkg::CTRL_OFS) || (paddr == flash_host_pkg::ADDR_OFS) ||
                   (paddr == flash_host_pkg::WDATA_OFS) || (paddr == flash_host_pkg::RDATA_OFS) ||
                   (paddr == flash_host_pkg::STATUS_OFS);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = prdata_ff;
   assign busy = (state_ff != flash_host_pkg::IDLE);
   // a go while busy is dropped; software checks the busy bit first
   assign go = apbWrite && (paddr == flash_host_pkg::CTRL_OFS) && pwdata[flash_host_pkg::CTRL_GO] && !busy;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         prdata_ff <= 32'h0000_0000;
      end else if (apbSetup && !pwrite) begin
         case (paddr)
            flash_host_pkg::CTRL_OFS: prdata_ff <= {26'h0, lockOvr_ff, wide_ff, bank_ff, op_ff, 1'b0};
            flash_host_pkg::ADDR_OFS: prdata_ff <= {11'h0, addr_ff};
            flash_host_pkg::WDATA_OFS: prdata_ff <= {16'h0, wdata_ff};
            flash_host_pkg::RDATA_OFS: prdata_ff <= {16'h0, rdata_ff};
            flash_host_pkg::STATUS_OFS: prdata_ff <= {28'h0, writeOk, pulseSeen_ff, statusSync, busy};
            default: prdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         op_ff <= flash_host_pkg::OP_WRITE;
         bank_ff <= 1'b0;
         wide_ff <= 1'b1;
         lockOvr_ff <= 1'b0;
         addr_ff <= 21'h00_0000;
         wdata_ff <= 16'h0000;
      end else if (apbWrite && !busy) begin
         case (paddr)
            flash_host_pkg::CTRL_OFS: begin
               op_ff <= pwdata[flash_host_pkg::CTRL_OP_LO +: 2];
               bank_ff <= pwdata[flash_host_pkg::CTRL_BANK];
               wide_ff <= pwdata[flash_host_pkg::CTRL_WIDE];
               lockOvr_ff <= pwdata[flash_host_pkg::CTRL_LOCK_OVR];
            end
            flash_host_pkg::ADDR_OFS: addr_ff <= pwdata[20:0];
            flash_host_pkg::WDATA_OFS: wdata_ff <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pulse mode capture
   // sticky, any low-going edge of the status pin held low two cycles or more; set wins over clear
   assign statusFall = statusPrev_ff && !statusSync;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         statusPrev_ff <= 1'b1;
         pulseSeen_ff <= 1'b0;
      end else begin
         statusPrev_ff <= statusSync;
         if (statusFall) begin
            pulseSeen_ff <= 1'b1;
         end else if (apbWrite && (paddr == flash_host_pkg::STATUS_OFS) && pwdata[flash_host_pkg::STAT_PULSE]) begin
            pulseSeen_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // wake timing
   // counts from reset pin release; reads and writes gated separately
   always_ff @(posedge clk) begin
      if (!resetn || !pdownN_ff) begin
         wakeCnt_ff <= 8'h00;
      end else if (wakeCnt_ff < flash_host_pkg::RESET_TO_WRITE_CYC) begin
         wakeCnt_ff <= wakeCnt_ff + 8'h01;
      end
   end

   assign readOk = wakeCnt_ff >= flash_host_pkg::RESET_TO_OUTPUT_CYC;
   assign writeOk = wakeCnt_ff >= flash_host_pkg::RESET_TO_WRITE_CYC;

   ////////////////////////////////////////////////////////////////////////
   // suspend allowed
   // write cycles go out whatever the status pin shows, so suspend works
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      case (state_ff)
         flash_host_pkg::IDLE: begin
            nxt_cnt = 8'h00;
            if (go) begin
               case (pwdata[flash_host_pkg::CTRL_OP_LO +: 2])
                  flash_host_pkg::OP_WRITE: nxt_state = flash_host_pkg::WSETUP;
                  flash_host_pkg::OP_READ: nxt_state = flash_host_pkg::RACCESS;
                  flash_host_pkg::OP_POLL: nxt_state = flash_host_pkg::POLL;
                  default: nxt_state = flash_host_pkg::PDOWN;
               endcase
            end
         end
         flash_host_pkg::PDOWN: begin
            nxt_cnt = cnt_ff + 8'h01;
            if (cnt_ff == flash_host_pkg::PD_PULSE_CYC - 8'h01) begin
               nxt_state = flash_host_pkg::IDLE;
            end
         end
         flash_host_pkg::WSETUP: begin
            if (writeOk) begin
               nxt_state = flash_host_pkg::WPULSE;
            end
         end
         flash_host_pkg::WPULSE: begin
            nxt_cnt = cnt_ff + 8'h01;
            if (cnt_ff == flash_host_pkg::WE_CYC - 8'h01) begin
               nxt_state = flash_host_pkg::WHOLD;
            end
         end
         flash_host_pkg::WHOLD: nxt_state = flash_host_pkg::IDLE;
         flash_host_pkg::RACCESS: begin
            if (readOk) begin
               nxt_cnt = cnt_ff + 8'h01;
               if (cnt_ff == flash_host_pkg::RD_CYC - 8'h01) begin
                  nxt_state = flash_host_pkg::RSAMPLE;
               end
            end
         end
         flash_host_pkg::RSAMPLE: nxt_state = flash_host_pkg::IDLE;
         flash_host_pkg::POLL: begin
            // settle first, the pin may not have fallen yet after a command
            if (cnt_ff < flash_host_pkg::POLL_CYC) begin
               nxt_cnt = cnt_ff + 8'h01;
            end else if (statusSync) begin
               nxt_state = flash_host_pkg::IDLE;
            end
         end
         default: nxt_state = flash_host_pkg::IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_ff <= flash_host_pkg::PDOWN;
         cnt_ff <= 8'h00;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin drivers, all registered from the next state
   always_ff @(posedge clk) begin
      if (!resetn) begin
         weN_ff <= 1'b1;
         oeN_ff <= 1'b1;
         dqOeN_ff <= 1'b1;
         pdownN_ff <= 1'b0;
         bankActive_ff <= 1'b0;
      end else begin
         // data held across write enable rise
         weN_ff <= nxt_state != flash_host_pkg::WPULSE;
         dqOeN_ff <= !(nxt_state == flash_host_pkg::WSETUP || nxt_state == flash_host_pkg::WPULSE ||
                       nxt_state == flash_host_pkg::WHOLD);
         oeN_ff <= !(nxt_state == flash_host_pkg::RACCESS || nxt_state == flash_host_pkg::RSAMPLE);
         pdownN_ff <= nxt_state != flash_host_pkg::PDOWN;
         bankActive_ff <= !(nxt_state == flash_host_pkg::IDLE || nxt_state == flash_host_pkg::PDOWN ||
                            nxt_state == flash_host_pkg::POLL);
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rdata_ff <= 16'h0000;
      end else if (state_ff == flash_host_pkg::RSAMPLE) begin
         // sampled only after the output delay
         rdata_ff <= wide_ff ? dqSync : {8'h00, dqSync[7:0]};
      end
   end

   // legal bank selects
   // bank 0 pairs with the low line, bank 1 with the high line, never both
   assign bank0_select_n = !bankActive_ff;
   assign bank1_low_select_n = !(bankActive_ff && !bank_ff);
   assign bank1_high_select_n = !(bankActive_ff && bank_ff);
   assign weN = weN_ff;
   assign oeN = oeN_ff;
   assign dqOeN = dqOeN_ff;
   assign powerdown_reset_n = pdownN_ff;
   assign flashAddr = addr_ff;
   assign dqOut = wide_ff ? wdata_ff : {8'h00, wdata_ff[7:0]};
   assign byteN = wide_ff;
   // override pin only; lock bits change by command cycles
   assign lockOverrideN = !lockOvr_ff;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence weLowSeq;
      $fell(weN) ##0 (!weN)[*2] ##1 weN;
   endsequence

   bank_select_legal_a: assert property (!(!bank0_select_n && !bank1_low_select_n && !bank1_high_select_n))
      else $error("all bank selects low together");
   write_after_wake_a: assert property (!weN |-> writeOk && powerdown_reset_n)
      else $error("write cycle before wake delay");
   read_after_wake_a: assert property (state_ff == flash_host_pkg::RSAMPLE |-> $past(readOk, 2))
      else $error("read sampled before output delay");
   we_pulse_width_a: assert property ($fell(weN) |-> weLowSeq)
      else $error("write pulse width wrong");
   data_held_a: assert property ($rose(weN) |-> !dqOeN && $stable(dqOut) && $stable(flashAddr))
      else $error("data released at write enable rise");
   no_we_oe_a: assert property (!(!weN && !oeN))
      else $error("write and output enable both low");
   pulse_capture_a: assert property (statusFall |=> pulseSeen_ff)
      else $error("status pulse lost");
   suspend_issue_a: assert property (go && pwdata[2:1] == flash_host_pkg::OP_WRITE && writeOk
                                     |-> ##2 $fell(weN))
      else $error("write cycle not issued while device busy");

endmodule

// file: testbench/flash_dev_model.sv
// behavioural two-bank flash seen from its pins
// assumes a pulled-up status line and one controller driving the pins
`timescale 1ns/1ps
module flash_dev_model #(
   parameter int PROG_NS = 1500
) (
   // address and data
   input wire logic [20:0] addr,
   input wire logic [15:0] din,
   input wire logic dinOeN,
   output logic [15:0] dq,
   // control
   input wire logic b0N,
   input wire logic b1lN,
   input wire logic b1hN,
   input wire logic weN,
   input wire logic oeN,
   input wire logic pdN,
   input wire logic byteN,
   input wire logic ovrN,
   // open drain status, high while pulling low
   output logic pinLow
);
   logic [15:0] mem [int];
   logic [63:0] lockBit = '0;
   logic busy = 0;
   logic statMode = 0;
   logic outOk = 0;
   logic wrOk = 0;
   logic [7:0] pend = 0;
   logic supplyLow = 0;
   logic [15:0] bufD [16];
   int bufK [16];
   int bufN = 0;
   int bufLeft = 0;
   logic [15:0] rv;
   int pdGen = 0;
   int g;
   int badSel = 0;
   event progGo;
   wire [21:0] key = {!b1hN, addr};
   wire sel = !b0N && (!b1lN || !b1hN);
   ////////////////////////////////////////
   // low only while running
   assign pinLow = busy && pdN;
   always @(b0N, b1lN, b1hN) if (!b0N && !b1lN && !b1hN) badSel++;
   always @(pdN) begin
      pdGen++;
      busy = 0;
      statMode = 0;
      pend = 0;
      outOk = 0;
      wrOk = 0;
      if (pdN) fork
         wake(pdGen);
      join_none
   end
   // a later pin change bumps pdGen, so stale wake timers do nothing
   task automatic wake(input int gen);
      #(flash_host_pkg::T_RESET_TO_OUTPUT_NS);
      if (gen == pdGen) outOk = 1;
      #(flash_host_pkg::T_RESET_TO_WRITE_NS - flash_host_pkg::T_RESET_TO_OUTPUT_NS);
      if (gen == pdGen) wrOk = 1;
   endtask
   always @(posedge weN) if (sel && pdN && !dinOeN && wrOk) cmd(din);
   task automatic cmd(input logic [15:0] d);
      if (busy) begin
         if (d[7:0] == 8'h70) statMode = 1;
      end else if (pend == 8'h40) begin
         pend = 0;
         if ((!lockBit[key[21:16]] || !ovrN) && !supplyLow) begin
            bufD[0] = d;
            bufK[0] = key;
            bufN = 1;
            ->progGo;
         end
      end else if (pend == 8'he8) begin
         // word count, then words into one 32-byte plane
         pend = 8'he9;
         bufN = 0;
         bufLeft = d[3:0] + 1;
      end else if (pend == 8'he9) begin
         if (bufLeft > 0) begin
            bufD[bufN] = d;
            bufK[bufN] = key;
            bufN++;
            bufLeft--;
         end else begin
            pend = 0;
            if (d[7:0] == 8'hd0 && (!lockBit[key[21:16]] || !ovrN) && !supplyLow) ->progGo;
         end
      end else if (pend == 8'h60) begin
         pend = 0;
         if (d[7:0] == 8'h01) lockBit[key[21:16]] = 1;
         if (d[7:0] == 8'hd0) lockBit = '0;
      end else begin
         case (d[7:0])
            8'hff: statMode = 0;
            8'h70: statMode = 1;
            8'h40, 8'h60, 8'he8: begin
               pend = d[7:0];
               statMode = 1;
            end
            default: ;
         endcase
      end
   endtask
   // engine times program of the loaded words
   // a reset during the run bumps pdGen, so the stale run writes nothing
   always @(progGo) begin
      g = pdGen;
      busy = 1;
      #(PROG_NS);
      if (g == pdGen) begin
         for (int i = 0; i < bufN; i++) begin
            mem[bufK[i]] = (mem.exists(bufK[i]) ? mem[bufK[i]] : 16'hffff) & bufD[i];
         end
         busy = 0;
      end
   end
   // read either bank, x8 leaves upper byte loose
   always @(oeN, sel, pdN, outOk, busy, statMode, key, byteN) begin
      rv = statMode ? {8'h00, !busy, 7'h00} : mem.exists(key) ? mem[key] : 16'hffff;
      if (!byteN) rv[15:8] = ~rv[15:8];
      dq = (!oeN && sel && pdN && outOk) ? rv : ~rv;
   end
endmodule

// file: testbench/flash_host_ctrl_test.sv
// self-checking bench for the apb flash host controller
// assumes the pin model on the far side and a pulled-up status line
`timescale 1ns/1ps
module flash_host_ctrl_test;
   localparam logic [7:0] CTL = flash_host_pkg::CTRL_OFS;
   localparam logic [7:0] ADR = flash_host_pkg::ADDR_OFS;
   localparam logic [7:0] WDT = flash_host_pkg::WDATA_OFS;
   localparam logic [7:0] RDT = flash_host_pkg::RDATA_OFS;
   localparam logic [7:0] STA = flash_host_pkg::STATUS_OFS;
   localparam logic [1:0] WR = flash_host_pkg::OP_WRITE;
   localparam logic [20:0] A1 = 21'h010020;
   localparam logic [20:0] A2 = 21'h000100;
   localparam logic [20:0] A3 = 21'h030004;
   logic clk = 0;
   logic resetn = 0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready, pslverr, dqOeN, b0N, b1lN, b1hN, weN, oeN, pdN, byteN, ovrN, pinLow, e;
   logic [20:0] flashAddr;
   logic [15:0] dqOut, dqIn;
   logic [31:0] q, ctrlBase;
   int errTotal = 0;
   int nCompared = 0;
   always #(flash_host_pkg::CLK_NS / 2) clk = ~clk;
   flash_host_ctrl uut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .flashAddr(flashAddr), .dqOut(dqOut), .dqOeN(dqOeN), .dqIn(dqIn), .bank0_select_n(b0N),
      .bank1_low_select_n(b1lN), .bank1_high_select_n(b1hN), .weN(weN), .oeN(oeN),
      .powerdown_reset_n(pdN), .byteN(byteN), .lockOverrideN(ovrN), .status_output_pin(!pinLow));
   flash_dev_model #(.PROG_NS(3000)) dev (.addr(flashAddr), .din(dqOut), .dinOeN(dqOeN), .dq(dqIn),
      .b0N(b0N), .b1lN(b1lN), .b1hN(b1hN), .weN(weN), .oeN(oeN), .pdN(pdN), .byteN(byteN),
      .ovrN(ovrN), .pinLow(pinLow));
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      nCompared++;
      if (seen !== exp) begin
         errTotal++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("compared %0d, mismatches %0d", nCompared, errTotal);
      if (errTotal == 0 && nCompared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic op(input logic [1:0] o, input logic [20:0] a, input logic [15:0] d);
      apb(1, ADR, {11'h0, a});
      apb(1, WDT, {16'h0, d});
      apb(1, CTL, ctrlBase | {29'h0, o, 1'b1});
      repeat (2) @(posedge clk);
      q = 1;
      while (q[0] !== 1'b0) apb(0, STA, 0);
   endtask
   task automatic prog(input logic [20:0] a, input logic [15:0] d);
      op(WR, a, 16'h0040);
      op(WR, a, d);
      op(flash_host_pkg::OP_POLL, a, 0);
   endtask
   task automatic rdf(input logic [20:0] a, input logic arr);
      if (arr) op(WR, a, 16'h00ff);
      op(flash_host_pkg::OP_READ, a, 0);
      apb(0, RDT, 0);
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (30000) @(posedge clk);
      errTotal++;
      conclude();
   end
   initial begin
      ctrlBase = 32'h10;
      repeat (10) @(posedge clk);
      chk({pdN, weN, oeN, dqOeN, b0N, b1lN, b1hN}, 32'h3f);
      resetn <= 1;
      apb(0, CTL, 0);
      chk(q, 32'h10);
      apb(0, 8'h14, 0);
      chk({q[30:0], e}, 32'h1);
      apb(0, STA, 0);
      chk(q[3], 0);
      prog(A1, 16'h1234);
      apb(0, STA, 0);
      chk(q[3:0], 4'he);
      apb(1, STA, 32'h4);
      apb(0, STA, 0);
      chk(q[2], 0);
      rdf(A1, 0);
      chk(q, 32'h80);
      rdf(A1, 1);
      chk(q, 32'h1234);
      op(WR, A2, 16'h0040);
      op(WR, A2, 16'h5678);
      op(WR, A2, 16'h00ff);
      repeat (6) @(posedge clk);
      apb(0, STA, 0);
      chk(q[1:0], 0);
      op(flash_host_pkg::OP_POLL, A2, 0);
      rdf(A2, 0);
      chk(q, 32'h80);
      rdf(A2, 1);
      chk(q, 32'h5678);
      op(WR, 21'h000200, 16'h0012);
      op(WR, 21'h000200, 16'hab00);
      rdf(21'h000200, 0);
      chk(q, 32'hffff);
      ctrlBase = 32'h18;
      prog(A1, 16'h00f0);
      rdf(A1, 1);
      chk(q, 32'h00f0);
      ctrlBase = 32'h10;
      rdf(A1, 0);
      chk(q, 32'h1234);
      ctrlBase = 32'h00;
      rdf(A1, 0);
      chk(q, 32'h34);
      chk(byteN, 0);
      ctrlBase = 32'h10;
      op(WR, A3, 16'h0060);
      op(WR, A3, 16'h0001);
      prog(A3, 16'h0f0f);
      rdf(A3, 1);
      chk(q, 32'hffff);
      ctrlBase = 32'h30;
      prog(A3, 16'h0f0f);
      rdf(A3, 1);
      chk(q, 32'h0f0f);
      ctrlBase = 32'h10;
      op(WR, A3, 16'h0060);
      op(WR, A3, 16'h00d0);
      prog(A3 + 21'h4, 16'h00aa);
      rdf(A3 + 21'h4, 1);
      chk(q, 32'h00aa);
      op(WR, 21'h000300, 16'h00e8);
      op(WR, 21'h000300, 16'h0001);
      op(WR, 21'h000300, 16'h1111);
      op(WR, 21'h000301, 16'h2222);
      op(WR, 21'h000300, 16'h00d0);
      op(flash_host_pkg::OP_POLL, 0, 0);
      rdf(21'h000301, 1);
      chk(q, 32'h2222);
      rdf(21'h000300, 0);
      chk(q, 32'h1111);
      dev.supplyLow = 1;
      prog(A3 + 21'h8, 16'h0055);
      rdf(A3 + 21'h8, 1);
      chk(q, 32'hffff);
      dev.supplyLow = 0;
      op(WR, A1, 16'h0070);
      op(flash_host_pkg::OP_RESET, 0, 0);
      rdf(A1, 0);
      chk(q, 32'h1234);
      chk(dev.badSel, 0);
      conclude();
   end
endmodule
